// ===== hw/tccu_pkg.sv
// Constants and types shared by the timer capture/compare unit
`default_nettype none
package tccu_pkg;
  // Register indices on the plain register port
  localparam logic [1:0] TCCU_ADDR_CTRL = 2'h0;
  localparam logic [1:0] TCCU_ADDR_VAL_LOW = 2'h1;
  localparam logic [1:0] TCCU_ADDR_VAL_HIGH = 2'h2;
  localparam logic [1:0] TCCU_ADDR_FLAG = 2'h3;
  // Register field layout and reset values
  localparam int TCCU_MODE_LSB = 0;
  localparam int TCCU_MODE_MSB = 3;
  localparam int TCCU_DUTY_LSB = 4;
  localparam int TCCU_DUTY_MSB = 5;
  localparam int TCCU_FLAG_BIT = 0;
  localparam logic [5:0] TCCU_CTRL_RESET = 6'h00;
  localparam logic [15:0] TCCU_VALUE_RESET = 16'h0000;
  localparam logic [7:0] TCCU_READ_ZERO = 8'h00;
  // Mode field encodings
  localparam logic [3:0] TCCU_MODE_OFF = 4'h0;
  localparam logic [3:0] TCCU_MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] TCCU_MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] TCCU_MODE_CAP_RISE4 = 4'h6;
  localparam logic [3:0] TCCU_MODE_CAP_RISE16 = 4'h7;
  localparam logic [3:0] TCCU_MODE_CMP_SET = 4'h8;
  localparam logic [3:0] TCCU_MODE_CMP_CLR = 4'h9;
  localparam logic [3:0] TCCU_MODE_CMP_SOFT = 4'ha;
  localparam logic [3:0] TCCU_MODE_CMP_TRIG = 4'hb;
  // Upper two mode bits select the group
  localparam logic [1:0] TCCU_GROUP_CAPTURE = 2'h1;
  localparam logic [1:0] TCCU_GROUP_COMPARE = 2'h2;
  // Edge prescaler counter
  localparam int TCCU_PRESC_W = 4;
  localparam logic [3:0] TCCU_PRESC_ZERO = 4'h0;
  localparam logic [3:0] TCCU_PRESC_ONE = 4'h1;
  localparam logic [3:0] TCCU_PRESC_LAST4 = 4'h3;
  localparam logic [3:0] TCCU_PRESC_LAST16 = 4'hf;
  localparam logic [3:0] TCCU_PRESC_MASK4 = 4'h3;
  // Capture event selection
  // Four-state base so the selection can travel on a net port
  typedef enum logic [2:0] {TCCU_EDGE_NONE, TCCU_EDGE_FALL, TCCU_EDGE_RISE, TCCU_EDGE_RISE4,
                TCCU_EDGE_RISE16} tccu_edge_t;
endpackage : tccu_pkg
`default_nettype wire

// ===== hw/tccu_edge_presc.sv
// Pin edge detector and capture edge prescaler
`timescale 1ns/1ps
`default_nettype none
module tccu_edge_presc (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic pin_level,
  input wire tccu_pkg::tccu_edge_t sel,
  output logic capture_evt
);
  import tccu_pkg::*;

  logic pin_prev_q; // Pin level one cycle ago
  logic [TCCU_PRESC_W-1:0] presc_q; // Rising edge count
  logic rise; // Rising edge this cycle
  logic fall; // Falling edge this cycle

  // The real pin level is watched, whoever drives it
  assign rise = pin_level & ~pin_prev_q;
  assign fall = ~pin_level & pin_prev_q;

  // Previous pin level
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pin_prev_q <= 1'b0;
    end else if (ce) begin
      pin_prev_q <= pin_level;
    end
  end

  // Prescaler: cleared outside capture, kept across capture changes
  always_ff @(posedge clk) begin
    if (!rstn) begin
      presc_q <= TCCU_PRESC_ZERO;
    end else if (ce) begin
      if (sel == TCCU_EDGE_NONE) begin
        presc_q <= TCCU_PRESC_ZERO;
      end else if (rise) begin
        presc_q <= presc_q + TCCU_PRESC_ONE;
      end
    end
  end

  // Event selection per mode
  always_comb begin
    case (sel)
      TCCU_EDGE_FALL: capture_evt = fall;
      TCCU_EDGE_RISE: capture_evt = rise;
      TCCU_EDGE_RISE4: begin
        capture_evt = rise & ((presc_q & TCCU_PRESC_MASK4) == TCCU_PRESC_LAST4);
      end
      TCCU_EDGE_RISE16: capture_evt = rise & (presc_q == TCCU_PRESC_LAST16);
      default: capture_evt = 1'b0;
    endcase
  end
endmodule : tccu_edge_presc
`default_nettype wire

// ===== hw/tccu_top.sv
// Capture/compare unit tied to timer one
`timescale 1ns/1ps
`default_nettype none
module tccu_top (
  input wire logic CORE_CLK,
  input wire logic RSTN,
  input wire logic CE,
  input wire logic [1:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic [15:0] TIMER_COUNT,
  input wire logic TIMER_TICK,
  input wire logic ADC_ENABLE,
  input wire logic PIN_IN,
  output logic PIN_OUT,
  output logic PIN_OE,
  output logic EVENT_FLAG,
  output logic SPECIAL_TRIGGER,
  output logic TIMER_RESET,
  output logic ADC_START
);
  import tccu_pkg::*;

  logic [5:0] ctrl_q; // Duty bits and mode field
  logic [3:0] mode; // Current mode field
  logic [15:0] value_q; // Capture/compare value pair
  logic flag_q; // Sticky event flag
  logic latch_q; // Compare output latch
  logic oe_q; // Unit owns the pin
  logic equal_q; // Equality seen last cycle
  logic pending_q; // Timer reset waiting for next timer tick
  logic trig_q; // Trigger pulse
  logic adc_q; // Conversion start pulse
  logic treset_q; // Timer reset pulse
  logic [7:0] rdata_q; // Read data register
  logic wr_ctrl; // Control write this cycle
  logic is_capture; // Capture group selected
  logic is_compare; // Compare group selected
  logic equal; // Timer equals value now
  logic match_rise; // New compare match
  logic capture_evt; // Capture event from prescaler
  logic flag_clr; // Software clear of the flag
  logic [3:0] new_mode; // Mode being written
  tccu_edge_t edge_sel; // Capture event selection

  assign mode = ctrl_q[TCCU_MODE_MSB:TCCU_MODE_LSB];
  assign new_mode = WDATA[TCCU_MODE_MSB:TCCU_MODE_LSB];
  assign wr_ctrl = CE & WR & (ADDR == TCCU_ADDR_CTRL);
  assign is_capture = (mode[3:2] == TCCU_GROUP_CAPTURE);
  assign is_compare = (mode[3:2] == TCCU_GROUP_COMPARE);
  // Equality checked on every cycle against the live timer
  assign equal = (TIMER_COUNT == value_q);
  // Only the first cycle of equality counts, so a standing match fires once
  assign match_rise = is_compare & equal & ~equal_q;
  assign flag_clr = CE & WR & (ADDR == TCCU_ADDR_FLAG) & WDATA[TCCU_FLAG_BIT];

  // Mode field to capture event selection
  always_comb begin
    case (mode)
      TCCU_MODE_CAP_FALL: edge_sel = TCCU_EDGE_FALL;
      TCCU_MODE_CAP_RISE: edge_sel = TCCU_EDGE_RISE;
      TCCU_MODE_CAP_RISE4: edge_sel = TCCU_EDGE_RISE4;
      TCCU_MODE_CAP_RISE16: edge_sel = TCCU_EDGE_RISE16;
      default: edge_sel = TCCU_EDGE_NONE;
    endcase
  end

  // Pin edge detection and prescaling
  tccu_edge_presc i_tccu_edge_presc (
    .clk(CORE_CLK),
    .rstn(RSTN),
    .ce(CE),
    .pin_level(PIN_IN),
    .sel(edge_sel),
    .capture_evt(capture_evt)
  );

  // Control register; upper bits are unimplemented
  // Bits 7:6 are not stored and read back as zero
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      ctrl_q <= TCCU_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= WDATA[TCCU_DUTY_MSB:0];
    end
  end

  // Value pair: capture wins over a software write
  // Halves are written independently, with no latching between bytes
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      value_q <= TCCU_VALUE_RESET;
    end else if (CE) begin
      if (capture_evt) begin
        value_q <= TIMER_COUNT;
      end else if (WR && ADDR == TCCU_ADDR_VAL_LOW) begin
        value_q[7:0] <= WDATA;
      end else if (WR && ADDR == TCCU_ADDR_VAL_HIGH) begin
        value_q[15:8] <= WDATA;
      end
    end
  end

  // Event flag: set wins over the software clear
  // An event in the cycle of a clear must not be lost
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      flag_q <= 1'b0;
    end else if (CE) begin
      if (capture_evt || match_rise) begin
        flag_q <= 1'b1;
      end else if (flag_clr) begin
        flag_q <= 1'b0;
      end
    end
  end

  // Compare output latch and pin ownership
  // Presetting the opposite level makes the first match visible on the pin
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      latch_q <= 1'b0;
      oe_q <= 1'b0;
    end else if (CE) begin
      if (wr_ctrl) begin
        // Only set and clear modes own the pin
        oe_q <= (new_mode == TCCU_MODE_CMP_SET) || (new_mode == TCCU_MODE_CMP_CLR);
        if (new_mode == TCCU_MODE_OFF) begin
          latch_q <= 1'b0;
        end else if (new_mode == TCCU_MODE_CMP_SET && mode != TCCU_MODE_CMP_SET) begin
          latch_q <= 1'b0;
        end else if (new_mode == TCCU_MODE_CMP_CLR && mode != TCCU_MODE_CMP_CLR) begin
          latch_q <= 1'b1;
        end
      end else if (match_rise && mode == TCCU_MODE_CMP_SET) begin
        latch_q <= 1'b1;
      end else if (match_rise && mode == TCCU_MODE_CMP_CLR) begin
        latch_q <= 1'b0;
      end
    end
  end

  // Equality history for match edge detection
  // Frozen with the clock enable so a paused timer cannot fake an edge
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      equal_q <= 1'b0;
    end else if (CE) begin
      equal_q <= equal;
    end
  end

  // Special trigger and conversion start, one pulse at the match
  // The converter start is gated by its enable at the moment of the match
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      trig_q <= 1'b0;
      adc_q <= 1'b0;
    end else if (CE) begin
      trig_q <= match_rise & (mode == TCCU_MODE_CMP_TRIG);
      adc_q <= match_rise & (mode == TCCU_MODE_CMP_TRIG) & ADC_ENABLE;
    end
  end

  // Timer reset waits for the next timer tick and a standing match
  // A tick in the match cycle itself is not counted as the next tick
  // Leaving the trigger mode drops a reset still waiting
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      pending_q <= 1'b0;
      treset_q <= 1'b0;
    end else if (CE) begin
      // Separate from the timer overflow flag, which it never touches
      treset_q <= TIMER_TICK & pending_q & equal & (mode == TCCU_MODE_CMP_TRIG);
      if (match_rise && mode == TCCU_MODE_CMP_TRIG) begin
        pending_q <= 1'b1;
      end else if (TIMER_TICK || mode != TCCU_MODE_CMP_TRIG) begin
        pending_q <= 1'b0;
      end
    end
  end

  // Read data, valid in the cycle after the read strobe
  // Returns to zero on an enabled cycle with no read pending; holds its last value while CE is low
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      rdata_q <= TCCU_READ_ZERO;
    end else if (CE) begin
      if (RD) begin
        case (ADDR)
          TCCU_ADDR_CTRL: rdata_q <= {2'h0, ctrl_q};
          TCCU_ADDR_VAL_LOW: rdata_q <= value_q[7:0];
          TCCU_ADDR_VAL_HIGH: rdata_q <= value_q[15:8];
          TCCU_ADDR_FLAG: rdata_q <= {7'h00, flag_q};
          default: rdata_q <= TCCU_READ_ZERO;
        endcase
      end else begin
        rdata_q <= TCCU_READ_ZERO;
      end
    end
  end

  // Outputs straight from flip-flops
  assign RDATA = rdata_q;
  assign PIN_OUT = latch_q;
  assign PIN_OE = oe_q;
  assign EVENT_FLAG = flag_q;
  assign SPECIAL_TRIGGER = trig_q;
  assign TIMER_RESET = treset_q;
  assign ADC_START = adc_q;

  // Checks on the behaviour above
  a_capture_value: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    CE && capture_evt |=> value_q == $past(TIMER_COUNT))
    else $error("captured value differs from timer count");
  a_capture_flag: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    CE && capture_evt |=> flag_q)
    else $error("capture did not set the event flag");
  a_flag_holds: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    flag_q && !(CE && WR && ADDR == TCCU_ADDR_FLAG) |=> flag_q)
    else $error("event flag cleared without software");
  a_match_flag: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    CE && match_rise |=> flag_q)
    else $error("compare match did not set the event flag");
  a_presc_clear: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    CE && !is_capture |=> i_tccu_edge_presc.presc_q == TCCU_PRESC_ZERO)
    else $error("prescaler not cleared outside capture");
  a_off_latch: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    wr_ctrl && new_mode == TCCU_MODE_OFF |=> !PIN_OUT && !PIN_OE)
    else $error("control write of zero left latch high");
  a_soft_nopin: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    mode == TCCU_MODE_CMP_SOFT && !wr_ctrl |=> !PIN_OE)
    else $error("software event mode took the pin");
  a_set_match: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    CE && match_rise && mode == TCCU_MODE_CMP_SET && !wr_ctrl |=> PIN_OUT && PIN_OE)
    else $error("set on match did not drive pin high");
  a_trig_now: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    CE && match_rise && mode == TCCU_MODE_CMP_TRIG |=> SPECIAL_TRIGGER ##1 !SPECIAL_TRIGGER)
    else $error("special trigger not a one cycle pulse at match");
  a_reset_cause: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    TIMER_RESET |-> $past(pending_q) && $past(equal) && $past(TIMER_TICK))
    else $error("timer reset without standing match at a tick");

  // Capture edges and prescaler
  a_fall_capture: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    CE && $past(CE) && mode == TCCU_MODE_CAP_FALL && $fell(PIN_IN) |-> capture_evt)
    else $error("falling edge missed in falling capture mode");
  a_rise_capture: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    CE && $past(CE) && mode == TCCU_MODE_CAP_RISE && $rose(PIN_IN) |-> capture_evt)
    else $error("rising edge missed in rising capture mode");
  a_presc_reset: assert property (@(posedge CORE_CLK)
    !RSTN |=> i_tccu_edge_presc.presc_q == TCCU_PRESC_ZERO)
    else $error("prescaler not cleared by reset");
  a_capture_pin: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    is_capture && !wr_ctrl |=> !PIN_OE)
    else $error("capture mode took the pin");

  // Flag clearing by software
  a_flag_clear: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    flag_clr && !capture_evt && !match_rise |=> !flag_q)
    else $error("software clear left the event flag set");

  // Compare matches and pin control
  a_match_seen: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    CE && $past(CE) && is_compare && equal && !$past(equal) |-> match_rise)
    else $error("new equality not taken as a match");
  a_clr_match: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    CE && match_rise && mode == TCCU_MODE_CMP_CLR && !wr_ctrl |=> !PIN_OUT && PIN_OE)
    else $error("clear on match did not drive pin low");
  a_set_preset: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    wr_ctrl && new_mode == TCCU_MODE_CMP_SET && mode != TCCU_MODE_CMP_SET |=> !PIN_OUT && PIN_OE)
    else $error("set mode entry did not preset pin low");
  a_clr_preset: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    wr_ctrl && new_mode == TCCU_MODE_CMP_CLR && mode != TCCU_MODE_CMP_CLR |=> PIN_OUT && PIN_OE)
    else $error("clear mode entry did not preset pin high");
  a_trig_nopin: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    mode == TCCU_MODE_CMP_TRIG && !wr_ctrl |=> !PIN_OE)
    else $error("trigger mode took the pin");

  // Trigger, conversion start and timer reset
  a_trig_cause: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    SPECIAL_TRIGGER && $past(CE) |-> $past(match_rise) && $past(mode) == TCCU_MODE_CMP_TRIG)
    else $error("special trigger without a match in trigger mode");
  a_adc_start: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    CE && match_rise && mode == TCCU_MODE_CMP_TRIG |=> ADC_START == $past(ADC_ENABLE))
    else $error("conversion start does not follow converter enable");
  a_reset_mode: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    TIMER_RESET |-> $past(mode) == TCCU_MODE_CMP_TRIG)
    else $error("timer reset outside trigger mode");
  a_pending_drop: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    CE && pending_q && TIMER_TICK && !equal |=> !TIMER_RESET && !pending_q)
    else $error("timer reset not skipped after lost match");

  // Scenario covers
  c_capture: cover property (@(posedge CORE_CLK) disable iff (!RSTN)
    CE && capture_evt && edge_sel == TCCU_EDGE_RISE16);
  c_trigger: cover property (@(posedge CORE_CLK) disable iff (!RSTN) TIMER_RESET);
  c_skip: cover property (@(posedge CORE_CLK) disable iff (!RSTN)
    CE && pending_q && TIMER_TICK && !equal);
  c_clear_pin: cover property (@(posedge CORE_CLK) disable iff (!RSTN)
    PIN_OE && $fell(PIN_OUT));
  c_fall_capture: cover property (@(posedge CORE_CLK) disable iff (!RSTN)
    CE && capture_evt && edge_sel == TCCU_EDGE_FALL);
endmodule : tccu_top
`default_nettype wire

// ===== tb/tccu_pin_model.sv
// Model of the outside world on the unit pin
`timescale 1ns/1ps
`default_nettype none
module tccu_pin_model (
  input wire logic ext_level,
  input wire logic unit_out,
  input wire logic unit_oe,
  output logic pin_level
);
  // The unit owns the pin while it drives; otherwise the outside source or port latch does,
  // and the unit always sees the real level on the wire
  assign pin_level = unit_oe ? unit_out : ext_level;
endmodule : tccu_pin_model
`default_nettype wire

// ===== tb/test_timer_capture_compare_unit.sv
// Self-checking bench for the capture/compare unit
`timescale 1ns/1ps
`default_nettype none
module test_timer_capture_compare_unit;
  import tccu_pkg::*;
  logic clk, rstn, ce, wr, rd, tick, adc_en, ext, pin, pout, poe, flag, trig, trst, adc;
  logic [1:0] addr;
  logic [7:0] wdata, rdata;
  logic [15:0] tcount;
  int error_cnt, comparisons, ntrig, nrst, nadc;
  logic [3:0] m;
  // Unit under test
  tccu_top i_tccu_top (.CORE_CLK(clk), .RSTN(rstn), .CE(ce), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .TIMER_COUNT(tcount), .TIMER_TICK(tick),
    .ADC_ENABLE(adc_en), .PIN_IN(pin), .PIN_OUT(pout), .PIN_OE(poe), .EVENT_FLAG(flag),
    .SPECIAL_TRIGGER(trig), .TIMER_RESET(trst), .ADC_START(adc));
  // Far side of the pin
  tccu_pin_model i_tccu_pin_model (.ext_level(ext), .unit_out(pout), .unit_oe(poe),
    .pin_level(pin));
  // Clock at 4 ns
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Pulse counters for the trigger outputs
  always @(posedge clk) begin
    if (trig === 1'b1) ntrig++;
    if (trst === 1'b1) nrst++;
    if (adc === 1'b1) nadc++;
  end
  // Compare and count
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Verdict and end of run
  task complete_run;
    $display("Errors %0d, comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run
  // One-cycle register write
  task wreg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  // One-cycle register read, data checked in the following cycle
  task rreg(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask : rreg
  // Wait n cycles and look just after the last edge
  task wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_n
  // Rising then falling pin edges from the outside source
  task edges(input int n);
    repeat (n) begin
      @(posedge clk);
      ext <= 1'b1;
      @(posedge clk);
      ext <= 1'b0;
    end
    wait_n(3);
  endtask : edges
  // Watchdog on the whole run
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    complete_run();
  end
  // Main sequence
  initial begin
    {rstn, wr, rd, tick, adc_en, ext} = '0;
    ce = 1'b1;
    addr = '0;
    wdata = '0;
    tcount = '0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    // Reset values and control field layout
    rreg(TCCU_ADDR_CTRL, 8'h00);
    rreg(TCCU_ADDR_VAL_LOW, 8'h00);
    rreg(TCCU_ADDR_FLAG, 8'h00);
    wreg(TCCU_ADDR_CTRL, 8'hf3);
    rreg(TCCU_ADDR_CTRL, 8'h33);
    // Rising-edge capture, then a second capture overwrites
    wreg(TCCU_ADDR_CTRL, 8'h05);
    tcount <= 16'h1234;
    edges(1);
    chk(flag, 1'b1);
    rreg(TCCU_ADDR_VAL_LOW, 8'h34);
    rreg(TCCU_ADDR_VAL_HIGH, 8'h12);
    @(posedge clk);
    tcount <= 16'h5678;
    edges(1);
    rreg(TCCU_ADDR_VAL_HIGH, 8'h56);
    wreg(TCCU_ADDR_FLAG, 8'h01);
    rreg(TCCU_ADDR_FLAG, 8'h00);
    // Falling-edge capture fires on the fall only
    wreg(TCCU_ADDR_CTRL, 8'h04);
    wreg(TCCU_ADDR_FLAG, 8'h01);
    tcount <= 16'h9abc;
    @(posedge clk);
    ext <= 1'b1;
    wait_n(3);
    chk(flag, 1'b0);
    @(posedge clk);
    ext <= 1'b0;
    wait_n(3);
    rreg(TCCU_ADDR_VAL_LOW, 8'hbc);
    // Prescaled captures: count only the nth rise, off between settings
    for (int k = 6; k <= 7; k++) begin
      wreg(TCCU_ADDR_CTRL, 8'h00);
      wreg(TCCU_ADDR_CTRL, 8'(k));
      wreg(TCCU_ADDR_FLAG, 8'h01);
      edges(k == 6 ? 3 : 15);
      chk(flag, 1'b0);
      edges(1);
      chk(flag, 1'b1);
    end
    // Clear-on-match then set-on-match, with latch preset and final forced low
    wreg(TCCU_ADDR_CTRL, 8'h00);
    wreg(TCCU_ADDR_VAL_LOW, 8'h00);
    wreg(TCCU_ADDR_VAL_HIGH, 8'h01);
    for (int k = 9; k >= 8; k--) begin
      m = 4'(k);
      @(posedge clk);
      tcount <= 16'h0000;
      wreg(TCCU_ADDR_CTRL, {4'h0, m});
      wreg(TCCU_ADDR_FLAG, 8'h01);
      wait_n(1);
      chk(poe, 1'b1);
      chk(pout, m[0]);
      @(posedge clk);
      tcount <= 16'h0100;
      wait_n(3);
      chk(pout, !m[0]);
      chk(flag, 1'b1);
    end
    wreg(TCCU_ADDR_CTRL, 8'h00);
    wait_n(1);
    chk(pout, 1'b0);
    chk(poe, 1'b0);
    // Software-event mode flags only
    @(posedge clk);
    tcount <= 16'h0000;
    wreg(TCCU_ADDR_CTRL, 8'h0a);
    wreg(TCCU_ADDR_FLAG, 8'h01);
    tcount <= 16'h0100;
    wait_n(3);
    chk(flag, 1'b1);
    chk(poe, 1'b0);
    chk(ntrig, 0);
    // Special trigger with converter on: trigger at once, reset at next tick
    @(posedge clk);
    tcount <= 16'h0000;
    adc_en <= 1'b1;
    wreg(TCCU_ADDR_CTRL, 8'h0b);
    wreg(TCCU_ADDR_FLAG, 8'h01);
    @(posedge clk);
    tcount <= 16'h0100;
    wait_n(1);
    chk(trig, 1'b1);
    chk(adc, 1'b1);
    chk(poe, 1'b0);
    @(posedge clk);
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
    #1 chk(trst, 1'b1);
    wait_n(2);
    chk(ntrig, 1);
    chk(nrst, 1);
    // Match removed before the tick skips the reset; converter off
    @(posedge clk);
    adc_en <= 1'b0;
    tcount <= 16'h0000;
    wait_n(2);
    @(posedge clk);
    tcount <= 16'h0100;
    wait_n(3);
    wreg(TCCU_ADDR_VAL_LOW, 8'h07);
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
    wait_n(3);
    chk(ntrig, 2);
    chk(nadc, 1);
    chk(nrst, 1);
    complete_run();
  end
endmodule : test_timer_capture_compare_unit
`default_nettype wire
